/* design/dsps_pkg.sv */
// shared constants, types and register map of the slot power sequencer
package dsps_pkg;

    // *****************************************************************
    // timing
    // *****************************************************************
    localparam int CLK_NS     = 40;
    localparam int OC_SENS_NS = 10000;
    localparam int UV_SENS_NS = 100000;
    localparam int CNT_W      = 12;
    localparam logic [CNT_W-1:0] OC_CYC =
        CNT_W'((OC_SENS_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [CNT_W-1:0] UV_CYC =
        CNT_W'((UV_SENS_NS + CLK_NS - 1) / CLK_NS);

    // *****************************************************************
    // register map
    // *****************************************************************
    localparam int NSLOT = 2;
    localparam int AW    = 4;
    localparam logic [AW-1:0] ADDR_CTRL = 4'h0;
    localparam logic [AW-1:0] ADDR_STAT = 4'h4;
    localparam logic [AW-1:0] ADDR_INT  = 4'h8;
    localparam logic [AW-1:0] ADDR_MASK = 4'hC;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int EVT_OC   = 0;
    localparam int EVT_UV   = 1;
    localparam int EVT_AUX  = 2;
    localparam int EVT_PER  = 3;
    localparam int NEVT     = 6;
    localparam int ST_PWR   = 0;
    localparam int ST_ARM   = 1;
    localparam int ST_LATCH = 2;
    localparam int ST_WAKE  = 3;
    localparam int ST_PER   = 4;
    localparam int ST_MODE  = 8;

    // *****************************************************************
    // state types
    // *****************************************************************
    typedef enum logic [1:0] {
        DSPS_OFF, DSPS_RAMP, DSPS_ON, DSPS_LATCHED
    } dsps_slot_e;

    typedef struct packed {
        dsps_slot_e       st;
        logic [CNT_W-1:0] oc_cnt;
        logic [CNT_W-1:0] uv_cnt;
        logic             gate12;
        logic             gate_low;
        logic             io_gate;
        logic             neg12;
        logic             bleed;
        logic             wake_val;
        logic             wake_oe;
        logic             aux_prev;
        logic             oc_evt;
        logic             uv_evt;
        logic             aux_evt;
    } dsps_slot_s;

    localparam dsps_slot_s SLOT_RST = '{st: DSPS_OFF, default: '0};

    typedef struct packed {
        logic            system_power_ok;
        logic            mode_serial;
        logic [1:0]      ctrl;
        logic            awready;
        logic            wready;
        logic            aw_got;
        logic            w_got;
        logic [AW-1:0]   awaddr;
        logic [31:0]     wdata;
        logic [3:0]      wstrb;
        logic            bvalid;
        logic [1:0]      bresp;
        logic            arready;
        logic            rvalid;
        logic [31:0]     rdata;
        logic [1:0]      rresp;
        logic [NEVT-1:0] int_st;
        logic [NEVT-1:0] int_mask;
        logic            irq;
    } dsps_top_s;

    localparam dsps_top_s TOP_RST = '{awready: 1'b1, wready: 1'b1,
                                      arready: 1'b1, default: '0};

endpackage

/* design/dsps_slot.sv */
// per-slot main and auxiliary power sequencing with fault latch
`timescale 1ns/1ps
module dsps_slot (
    input  wire logic core_clk_in,
    input  wire logic srst_in,
    input  wire logic cmd_in,
    input  wire logic inputs_ok_in,
    input  wire logic gate12_good_in,
    input  wire logic gate_low_good_in,
    input  wire logic low_below_1v_in,
    input  wire logic over_current_in,
    input  wire logic under_voltage_in,
    input  wire logic aux_good_in,
    input  wire logic aux_fault_in,
    input  wire logic sw_open_in,
    input  wire logic wake_in,
    output dsps_pkg::dsps_slot_s q_out
);
    import dsps_pkg::*;

    dsps_slot_s q;
    dsps_slot_s d;

    assign q_out = q;

    always_comb begin
        d = q;
        d.oc_evt = 1'b0;
        d.uv_evt = 1'b0;
        d.aux_evt = 1'b0;
        unique case (q.st)
            DSPS_OFF: begin
                if (cmd_in && inputs_ok_in) begin // [RULE6]
                    d.st = DSPS_RAMP;
                    d.gate12 = 1'b1; // [RULE8]
                    d.gate_low = 1'b1; // [RULE8]
                    d.neg12 = 1'b1;
                    d.oc_cnt = '0;
                    d.uv_cnt = '0;
                end
            end
            DSPS_RAMP, DSPS_ON: begin
                // sensitivity filters restart whenever the fault clears
                d.oc_cnt = over_current_in ? q.oc_cnt + 1'b1 : '0; // [RULE15]
                d.uv_cnt = (q.st == DSPS_ON && under_voltage_in) ?
                           q.uv_cnt + 1'b1 : '0; // [RULE5] [RULE15]
                if (q.st == DSPS_RAMP && gate12_good_in && gate_low_good_in)
                    d.st = DSPS_ON; // [RULE5]
                if (!cmd_in) begin
                    d.st = DSPS_OFF;
                    d.gate12 = 1'b0;
                    d.gate_low = 1'b0;
                    d.neg12 = 1'b0; // [RULE12]
                end else if (over_current_in && q.oc_cnt == OC_CYC) begin
                    d.st = DSPS_LATCHED; // [RULE9]
                    d.oc_evt = 1'b1;
                end else if (q.st == DSPS_ON && under_voltage_in &&
                             q.uv_cnt == UV_CYC) begin
                    d.st = DSPS_LATCHED; // [RULE11]
                    d.uv_evt = 1'b1;
                end
                if (d.st == DSPS_LATCHED) begin
                    d.gate12 = 1'b0;
                    d.gate_low = 1'b0;
                    d.neg12 = 1'b0; // [RULE12]
                end
            end
            DSPS_LATCHED: begin
                if (!cmd_in)
                    d.st = DSPS_OFF; // [RULE10]
            end
        endcase
        // io gate rises with power, falls once low gate is under 1 V
        if (d.gate_low)
            d.io_gate = 1'b1; // [RULE1]
        else if (low_below_1v_in)
            d.io_gate = 1'b0; // [RULE1]
        // auxiliary path never looks at main state
        d.bleed = aux_fault_in | sw_open_in; // [RULE4] [RULE13]
        if (aux_fault_in || sw_open_in)
            d.wake_oe = 1'b0; // [RULE3]
        else if (aux_good_in)
            d.wake_oe = 1'b1; // [RULE2]
        d.wake_val = wake_in;
        d.aux_prev = aux_fault_in;
        d.aux_evt = aux_fault_in & ~q.aux_prev;
    end

    always_ff @(posedge core_clk_in) begin
        if (srst_in)
            q <= SLOT_RST;
        else
            q <= d;
    end

endmodule

/* design/dsps_top.sv */
// dual slot power sequencer top with register slave and interrupt
// Operation
// RULE1: io gate on with slot power; off only once low gate is under 1 V
// RULE2: close wake event switch only after aux supply reports good
// RULE3: open wake event switch at once on aux fault or open latch switch
// RULE4: bleed aux output while aux faults or latch switch is open
// RULE5: ignore output under-voltage until both gate-good signals are true
// RULE6: start main power only with all inputs good and power commanded
// RULE7: controller commands power by pin in direct, by command in serial
// RULE8: 12 V and low main gate ramps start in the same cycle
// RULE9: latch slot off when over-current outlasts its sensitivity time
// RULE10: latched slot restarts only after command goes off then on
// RULE11: once armed, latch slot off when under-voltage outlasts its time
// RULE12: negative 12 V switch off on command release or main fault
// RULE13: aux control is fully independent of main supplies
// RULE14: sample direct or serial mode on rising system power ok
// RULE15: sensitivity times are cycle counters cleared when fault clears
`timescale 1ns/1ps
module dsps_top (
    input  wire logic                      core_clk_in,
    input  wire logic                      srst_in,
    input  wire logic                      system_power_ok_in,
    input  wire logic                      mode_serial_in,
    input  wire logic [1:0]                slot_power_request_pin_in,
    input  wire logic                      inputs_ok_in,
    input  wire logic [1:0]                twelve_gate_good_in,
    input  wire logic [1:0]                main_low_gate_good_in,
    input  wire logic [1:0]                main_low_below_1v_in,
    input  wire logic [1:0]                over_current_in,
    input  wire logic [1:0]                under_voltage_in,
    input  wire logic [1:0]                aux_good_in,
    input  wire logic [1:0]                aux_fault_in,
    input  wire logic [1:0]                latch_switch_open_in,
    input  wire logic [1:0]                wake_event_in,
    input  wire logic [dsps_pkg::AW-1:0]   s_axi_awaddr,
    input  wire logic                      s_axi_awvalid,
    output logic                           s_axi_awready,
    input  wire logic [31:0]               s_axi_wdata,
    input  wire logic [3:0]                s_axi_wstrb,
    input  wire logic                      s_axi_wvalid,
    output logic                           s_axi_wready,
    output logic [1:0]                     s_axi_bresp,
    output logic                           s_axi_bvalid,
    input  wire logic                      s_axi_bready,
    input  wire logic [dsps_pkg::AW-1:0]   s_axi_araddr,
    input  wire logic                      s_axi_arvalid,
    output logic                           s_axi_arready,
    output logic [31:0]                    s_axi_rdata,
    output logic [1:0]                     s_axi_rresp,
    output logic                           s_axi_rvalid,
    input  wire logic                      s_axi_rready,
    output logic [1:0]                     twelve_volt_gate_out,
    output logic [1:0]                     main_low_gate_out,
    output logic [1:0]                     io_voltage_gate_out,
    output logic [1:0]                     neg_twelve_on_out,
    output logic [1:0]                     aux_bleed_out,
    output logic [1:0]                     wake_event_out,
    output logic [1:0]                     wake_event_oe_out,
    output logic                           irq_out
);
    import dsps_pkg::*;

    dsps_top_s       q;
    dsps_top_s       d;
    dsps_slot_s      sq [NSLOT];
    logic [1:0]      slot_cmd;
    logic [1:0]      powered;
    logic [1:0]      armed;
    logic [1:0]      latched;
    logic [NEVT-1:0] evt;
    logic [31:0]     stat_word;

    // *****************************************************************
    // slot instances
    // *****************************************************************
    // direct mode uses the pins, serial mode the command register
    assign slot_cmd = q.system_power_ok ?
        (q.mode_serial ? q.ctrl : slot_power_request_pin_in) :
        2'b00; // [RULE7]

    for (genvar g = 0; g < NSLOT; g++) begin : g_slot
        dsps_slot u_slot (
            .core_clk_in      (core_clk_in),
            .srst_in          (srst_in),
            .cmd_in           (slot_cmd[g]),
            .inputs_ok_in     (inputs_ok_in),
            .gate12_good_in   (twelve_gate_good_in[g]),
            .gate_low_good_in (main_low_gate_good_in[g]),
            .low_below_1v_in  (main_low_below_1v_in[g]),
            .over_current_in  (over_current_in[g]),
            .under_voltage_in (under_voltage_in[g]),
            .aux_good_in      (aux_good_in[g]),
            .aux_fault_in     (aux_fault_in[g]),
            .sw_open_in       (latch_switch_open_in[g]),
            .wake_in          (wake_event_in[g]),
            .q_out            (sq[g])
        );
        assign twelve_volt_gate_out[g] = sq[g].gate12;
        assign main_low_gate_out[g]    = sq[g].gate_low;
        assign io_voltage_gate_out[g]  = sq[g].io_gate;
        assign neg_twelve_on_out[g]    = sq[g].neg12;
        assign aux_bleed_out[g]        = sq[g].bleed;
        assign wake_event_out[g]       = sq[g].wake_val;
        assign wake_event_oe_out[g]    = sq[g].wake_oe;
        assign powered[g] = sq[g].st == DSPS_RAMP || sq[g].st == DSPS_ON;
        assign armed[g]   = sq[g].st == DSPS_ON;
        assign latched[g] = sq[g].st == DSPS_LATCHED;
        assign evt[g*EVT_PER+EVT_OC]  = sq[g].oc_evt;
        assign evt[g*EVT_PER+EVT_UV]  = sq[g].uv_evt;
        assign evt[g*EVT_PER+EVT_AUX] = sq[g].aux_evt;
        assign stat_word[g*ST_PER+ST_PWR]   = powered[g];
        assign stat_word[g*ST_PER+ST_ARM]   = armed[g];
        assign stat_word[g*ST_PER+ST_LATCH] = latched[g];
        assign stat_word[g*ST_PER+ST_WAKE]  = sq[g].wake_oe;
    end
    assign stat_word[ST_MODE]    = q.mode_serial;
    assign stat_word[31:ST_MODE+1] = '0;

    // *****************************************************************
    // register slave and interrupt
    // *****************************************************************
    always_comb begin
        logic [NEVT-1:0] clr;
        clr = '0;
        d = q;
        d.system_power_ok = system_power_ok_in;
        if (system_power_ok_in && !q.system_power_ok)
            d.mode_serial = mode_serial_in; // [RULE14]
        // write address and data in either order
        if (s_axi_awvalid && q.awready) begin
            d.aw_got = 1'b1;
            d.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && q.wready) begin
            d.w_got = 1'b1;
            d.wdata = s_axi_wdata;
            d.wstrb = s_axi_wstrb;
        end
        if (q.bvalid && s_axi_bready)
            d.bvalid = 1'b0;
        if (q.aw_got && q.w_got && !q.bvalid) begin
            d.aw_got = 1'b0;
            d.w_got = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = RESP_OKAY;
            unique case (q.awaddr)
                ADDR_CTRL: begin
                    if (q.wstrb[0])
                        d.ctrl = q.wdata[1:0];
                end
                ADDR_MASK: begin
                    if (q.wstrb[0])
                        d.int_mask = q.wdata[NEVT-1:0];
                end
                ADDR_STAT, ADDR_INT: d.bresp = RESP_OKAY;
                default: d.bresp = RESP_SLVERR;
            endcase
        end
        d.awready = !d.aw_got && !d.bvalid;
        d.wready = !d.w_got && !d.bvalid;
        // read channel, one outstanding read
        if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
            d.arready = 1'b1;
        end
        if (s_axi_arvalid && q.arready) begin
            d.rvalid = 1'b1;
            d.arready = 1'b0;
            d.rresp = RESP_OKAY;
            d.rdata = '0;
            unique case (s_axi_araddr)
                ADDR_CTRL: d.rdata[1:0] = q.ctrl;
                ADDR_STAT: d.rdata = stat_word;
                ADDR_INT: begin
                    d.rdata[NEVT-1:0] = q.int_st;
                    clr = q.int_st;
                end
                ADDR_MASK: d.rdata[NEVT-1:0] = q.int_mask;
                default: d.rresp = RESP_SLVERR;
            endcase
        end
        // new events win over the read-clear
        d.int_st = (q.int_st & ~clr) | evt;
        d.irq = |(d.int_st & d.int_mask);
    end

    always_ff @(posedge core_clk_in) begin
        if (srst_in)
            q <= TOP_RST;
        else
            q <= d;
    end

    assign s_axi_awready = q.awready;
    assign s_axi_wready  = q.wready;
    assign s_axi_bvalid  = q.bvalid;
    assign s_axi_bresp   = q.bresp;
    assign s_axi_arready = q.arready;
    assign s_axi_rvalid  = q.rvalid;
    assign s_axi_rdata   = q.rdata;
    assign s_axi_rresp   = q.rresp;
    assign irq_out       = q.irq;

    // *****************************************************************
    // assertions
    // *****************************************************************
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (srst_in);

    for (genvar g = 0; g < NSLOT; g++) begin : g_chk
        AST_IO_WITH_POWER: assert property ( // [RULE1]
            main_low_gate_out[g] |-> io_voltage_gate_out[g])
            else $error("io gate low while main power on");
        AST_IO_RELEASE: assert property ( // [RULE1]
            $fell(io_voltage_gate_out[g]) |->
            $past(main_low_below_1v_in[g]) && !main_low_gate_out[g])
            else $error("io gate released above 1 V");
        AST_WAKE_CLOSE: assert property ( // [RULE2]
            $rose(wake_event_oe_out[g]) |-> $past(aux_good_in[g]))
            else $error("wake switch closed without aux good");
        AST_WAKE_OPEN: assert property ( // [RULE3]
            (aux_fault_in[g] || latch_switch_open_in[g]) |=>
            !wake_event_oe_out[g])
            else $error("wake switch not opened on aux fault");
        AST_BLEED: assert property ( // [RULE4]
            ##1 aux_bleed_out[g] ==
            $past(aux_fault_in[g] || latch_switch_open_in[g]))
            else $error("aux bleed mismatch");
        AST_UV_ARMED: assert property ( // [RULE5]
            sq[g].uv_evt |-> $past(armed[g]) &&
            $past(under_voltage_in[g]))
            else $error("under-voltage latch before arming");
        AST_START: assert property ( // [RULE6]
            $rose(powered[g]) |-> $past(inputs_ok_in && slot_cmd[g]))
            else $error("main power started without permission");
        AST_GATES_TOGETHER: assert property ( // [RULE8]
            twelve_volt_gate_out[g] == main_low_gate_out[g])
            else $error("gate ramps not started together");
        AST_OC_TIME: assert property ( // [RULE9]
            sq[g].oc_evt |-> $past(over_current_in[g]) &&
            $past(over_current_in[g], 250) && latched[g])
            else $error("over-current latch too early");
        AST_OC_FILTER: assert property ( // [RULE15]
            (powered[g] && !over_current_in[g]) |=> sq[g].oc_cnt == '0)
            else $error("over-current count not cleared");
        AST_LATCH_HOLD: assert property ( // [RULE10]
            (latched[g] && slot_cmd[g]) |=>
            latched[g] && !twelve_volt_gate_out[g])
            else $error("latched slot restarted without toggle");
        AST_NEG12_OFF: assert property ( // [RULE12]
            (!slot_cmd[g] || latched[g]) |=> !neg_twelve_on_out[g])
            else $error("negative 12 V left on");
        AST_AUX_INDEP: assert property ( // [RULE13]
            $changed(wake_event_oe_out[g]) |->
            $past(aux_fault_in[g] || latch_switch_open_in[g] ||
                  aux_good_in[g]))
            else $error("wake switch moved without aux cause");
        AST_UV_IGNORED: assert property ( // [RULE5]
            (powered[g] && !armed[g]) |=> sq[g].uv_cnt == '0)
            else $error("under-voltage counted before arming");
        AST_LATCH_OFF: assert property ( // [RULE9] [RULE11]
            $rose(latched[g]) |->
            !twelve_volt_gate_out[g] && !neg_twelve_on_out[g])
            else $error("latched slot left powered");
        AST_START_NOW: assert property ( // [RULE6] [RULE8]
            (!powered[g] && !latched[g] && slot_cmd[g] && inputs_ok_in)
            |=> twelve_volt_gate_out[g] && main_low_gate_out[g])
            else $error("commanded slot did not start");
        COV_OC_LATCH: cover property (sq[g].oc_evt);
        COV_UV_LATCH: cover property (sq[g].uv_evt);
        COV_WAKE: cover property ($rose(wake_event_oe_out[g]));
    end

    AST_MODE_SAMPLE: assert property ( // [RULE14]
        $changed(q.mode_serial) |-> $past(system_power_ok_in) &&
        (!$past(system_power_ok_in, 2) || $past(srst_in, 2)))
        else $error("mode changed without power ok rise");
    AST_IRQ: assert property (
        |(evt & q.int_mask) ##1 $stable(q.int_mask) |-> irq_out)
        else $error("unmasked event raised no interrupt");
    COV_READ: cover property (s_axi_rvalid && s_axi_rready);
    COV_SERIAL_ON: cover property (q.mode_serial && |powered);

    // *****************************************************************
    // register bus checks
    // *****************************************************************
    AST_INT_SET_WINS: assert property (
        |evt |=> (q.int_st & $past(evt)) == $past(evt))
        else $error("event lost against read clear");
    AST_B_HOLD: assert property (
        s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    AST_R_HOLD: assert property (
        s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    AST_R_LATENCY: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    AST_W_BUSY: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");

endmodule

/* testbench/dsps_host_model.sv */
// host controller model driving the direct power request pins
`timescale 1ns/1ps
module dsps_host_model (
    input  wire logic       core_clk_in,
    input  wire logic       srst_in,
    input  wire logic [1:0] power_cmd_in,
    output logic      [1:0] request_pin_out
);
    // *****************************************************************
    // pin driver
    // *****************************************************************
    // a restart is only a low then high level on the pin
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            request_pin_out <= 2'h0;
        end else begin
            request_pin_out <= power_cmd_in;
        end
    end
endmodule

/* testbench/test_dsps_top.sv */
// self-checking bench of the slot power sequencer top
`timescale 1ns/1ps
module test_dsps_top;
    import dsps_pkg::*;
    logic        clk, rst, pok, mser, iok;
    logic [1:0]  cmd, pin, g12, glo, b1v, oc, uv, ag, af, sw, wk;
    logic [3:0]  awa, ara, ws;
    logic [31:0] wd, rd;
    logic        awv, wv, br, arv, rr, awr, wr, bv, arr, rv, irq;
    logic [1:0]  bre, rre, g12o, gloo, iog, n12, bld, wko, wkoe;
    int          errors, cmp_count, cyc;
    // *****************************************************************
    // instances
    // *****************************************************************
    dsps_host_model u_dsps_host_model (.core_clk_in(clk), .srst_in(rst),
        .power_cmd_in(cmd), .request_pin_out(pin));
    dsps_top u_dsps_top (.core_clk_in(clk), .srst_in(rst),
        .system_power_ok_in(pok), .mode_serial_in(mser),
        .slot_power_request_pin_in(pin), .inputs_ok_in(iok),
        .twelve_gate_good_in(g12), .main_low_gate_good_in(glo),
        .main_low_below_1v_in(b1v), .over_current_in(oc),
        .under_voltage_in(uv), .aux_good_in(ag), .aux_fault_in(af),
        .latch_switch_open_in(sw), .wake_event_in(wk),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
        .s_axi_wready(wr), .s_axi_bresp(bre), .s_axi_bvalid(bv),
        .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rre),
        .s_axi_rvalid(rv), .s_axi_rready(rr),
        .twelve_volt_gate_out(g12o), .main_low_gate_out(gloo),
        .io_voltage_gate_out(iog), .neg_twelve_on_out(n12),
        .aux_bleed_out(bld), .wake_event_out(wko),
        .wake_event_oe_out(wkoe), .irq_out(irq));
    // *****************************************************************
    // clock and timeout
    // *****************************************************************
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors = errors + 1;
            complete_run();
        end
    end
    // *****************************************************************
    // tasks
    // *****************************************************************
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count = cmp_count + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
                          input logic [1:0] er);
        @(posedge clk);
        awa <= a;
        wd  <= d;
        awv <= 1'b1;
        wv  <= 1'b1;
        br  <= 1'b1;
        do begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wr) wv <= 1'b0;
        end while (!bv);
        br <= 1'b0;
        chk(bre, er);
    endtask
    task automatic axi_rd(input logic [3:0] a, input logic [31:0] ed,
                          input logic [1:0] er);
        @(posedge clk);
        ara <= a;
        arv <= 1'b1;
        rr  <= 1'b1;
        do begin
            @(posedge clk);
            if (arr) arv <= 1'b0;
        end while (!rv);
        rr <= 1'b0;
        chk(rre, er);
        chk(rd, ed);
    endtask
    task automatic complete_run();
        $display("errors=%0d cmp_count=%0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // *****************************************************************
    // main sequence
    // *****************************************************************
    initial begin
        errors = 0; cmp_count = 0; rst = 1'b1; pok = 1'b1;
        mser = 1'b0; iok = 1'b0; cmd = 2'h0; g12 = 2'h0; glo = 2'h0;
        b1v = 2'h0; oc = 2'h0; uv = 2'h0; ag = 2'h0; af = 2'h0;
        sw = 2'h0; wk = 2'h0; awa = 4'h0; ara = 4'h0; wd = 32'h0;
        ws = 4'hF; awv = 1'b0; wv = 1'b0; br = 1'b0; arv = 1'b0; rr = 1'b0;
        tick(16);
        rst <= 1'b0;
        tick(2);
        chk(g12o, 32'h0); chk(wkoe, 32'h0); chk(irq, 32'h0);
        axi_rd(ADDR_STAT, 32'h0, RESP_OKAY);
        axi_rd(4'h2, 32'h0, RESP_SLVERR);
        axi_wr(4'h6, 32'h3, RESP_SLVERR);
        axi_wr(ADDR_MASK, 32'h3F, RESP_OKAY);
        cmd <= 2'h1;
        tick(5);
        chk(g12o, 32'h0);
        iok <= 1'b1;
        repeat (5) begin
            tick(1);
            chk(gloo, g12o);
        end
        chk(g12o, 32'h1);
        chk(n12, 32'h1);
        chk(iog, 32'h1);
        uv <= 2'h1;
        tick(2600);
        chk(g12o, 32'h1);
        g12 <= 2'h1; glo <= 2'h1;
        tick(3);
        axi_rd(ADDR_STAT, 32'h3, RESP_OKAY);
        tick(2510);
        chk(g12o, 32'h0);
        chk(n12, 32'h0);
        chk(iog, 32'h1);
        chk(irq, 32'h1);
        axi_rd(ADDR_INT, 32'h2, RESP_OKAY);
        tick(2);
        chk(irq, 32'h0);
        axi_rd(ADDR_STAT, 32'h4, RESP_OKAY);
        uv <= 2'h0; g12 <= 2'h0; glo <= 2'h0;
        tick(5);
        chk(g12o, 32'h0);
        cmd <= 2'h0; tick(4); cmd <= 2'h1; tick(5);
        chk(g12o, 32'h1);
        oc <= 2'h1; tick(250); oc <= 2'h0; tick(1);
        oc <= 2'h1; tick(250); oc <= 2'h0; tick(3);
        chk(g12o, 32'h1);
        oc <= 2'h1; tick(260); oc <= 2'h0;
        chk(g12o, 32'h0);
        axi_rd(ADDR_INT, 32'h1, RESP_OKAY);
        cmd <= 2'h0; tick(4);
        chk(iog, 32'h1);
        b1v <= 2'h1; tick(3);
        chk(iog, 32'h0);
        b1v <= 2'h0; cmd <= 2'h1; tick(5);
        chk(wkoe, 32'h0);
        ag <= 2'h1; wk <= 2'h1; tick(3);
        chk(wkoe, 32'h1); chk(wko, 32'h1);
        af <= 2'h1;
        tick(2);
        chk(wkoe, 32'h0);
        chk(bld, 32'h1);
        chk(g12o, 32'h1);
        // status bit lands one edge after the slot event, irq with it
        tick(1);
        chk(irq, 32'h1);
        axi_rd(ADDR_INT, 32'h4, RESP_OKAY);
        af <= 2'h0; tick(3);
        chk(wkoe, 32'h1); chk(bld, 32'h0);
        sw <= 2'h1; tick(2);
        chk(wkoe, 32'h0); chk(bld, 32'h1);
        sw <= 2'h0;
        axi_wr(ADDR_MASK, 32'h0, RESP_OKAY);
        af <= 2'h1; tick(3); af <= 2'h0;
        chk(irq, 32'h0);
        axi_rd(ADDR_INT, 32'h4, RESP_OKAY);
        cmd <= 2'h0; pok <= 1'b0; mser <= 1'b1; tick(4);
        pok <= 1'b1; cmd <= 2'h1; tick(4);
        axi_rd(ADDR_STAT, 32'h108, RESP_OKAY);
        chk(g12o, 32'h0);
        axi_wr(ADDR_CTRL, 32'h2, RESP_OKAY);
        tick(4);
        chk(g12o, 32'h2); chk(gloo, 32'h2);
        complete_run();
    end
endmodule
